// ---- hdl/step14_cfg_pkg.sv ----
package step14_cfg_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 16;
    localparam logic [7:0] STEP14_SETUP_ADDR = 8'h9E;
    localparam logic [15:0] STEP14_SETUP_RESET = 16'h000E;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ENABLE_POS = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int NEG_POS = 4;
    localparam int POS_HI = 3;
    localparam int POS_LO = 0;
    localparam logic [15:0] WRITABLE_MASK = 16'hE01F;
    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
    localparam logic [3:0] POS_SHORT_GND = 4'h9;
    localparam logic [3:0] POS_TEST_DAC = 4'hA;
    localparam logic [3:0] POS_ANALOG_SUPPLY = 4'hB;
    localparam logic [3:0] POS_IO_SUPPLY = 4'hC;
    localparam logic [3:0] POS_DIGITAL_SUPPLY = 4'hD;
    localparam logic [3:0] POS_ANALOG_POWER = 4'hE;
    localparam logic [3:0] POS_DIGITAL_POWER = 4'hF;
    localparam logic [2:0] GAIN_X1 = 3'h1;
    localparam logic [2:0] GAIN_X2 = 3'h2;
    localparam logic [2:0] GAIN_X4 = 3'h4;
    // Negative input routing, one-hot
    typedef enum logic [2:0] {
        NEG_GROUND = 3'h1,
        NEG_INPUT7 = 3'h2,
        NEG_AUTO = 3'h4
    } neg_route_type;
endpackage

// ---- hdl/step14_cfg_reg.sv ----
`timescale 1ns/1ps
// Behaviour
// [R1] Register sits at 9Eh and resets to 000Eh.
// [R2] Bit 15 enables step 14; clear means the sequencer skips it.
// [R3] Bits 14:13 pick gain: 00 one, 01 two, 10 and 11 four.
// [R4] Bit 4 picks negative input: 0 ground reference, 1 external input 7.
// [R5] Bits 3:0 codes 0 to 7 route external inputs 0 to 7.
// [R6] Codes 8 to 15 route the eight internal sources in listed order.
// [R7] Internal sources select negative input automatically, ignoring bit 4.
// [R8] Bits 12:5 read zero and ignore writes.
module step14_cfg_reg (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Sequencer view
    output logic step_enable_out,
    output logic [2:0] gain_onehot_out,
    output logic [7:0] ext_pos_onehot_out,
    output logic [7:0] int_src_onehot_out,
    output step14_cfg_pkg::neg_route_type neg_route_out
);
    // ----------------------------------------
    // Reset view of the sequencer outputs
    // ----------------------------------------
    function automatic logic [7:0] src_onehot(input logic [2:0] idx);
        src_onehot = 8'h01 << idx;
    endfunction

    function automatic logic [2:0] gain_of(input logic [1:0] code);
        case (code)
            2'h0: gain_of = step14_cfg_pkg::GAIN_X1;
            2'h1: gain_of = step14_cfg_pkg::GAIN_X2;
            default: gain_of = step14_cfg_pkg::GAIN_X4;
        endcase
    endfunction

    function automatic step14_cfg_pkg::neg_route_type neg_of(input logic [3:0] pos,
        input logic neg);
        if (pos[3]) begin
            neg_of = step14_cfg_pkg::NEG_AUTO;
        end else if (neg) begin
            neg_of = step14_cfg_pkg::NEG_INPUT7;
        end else begin
            neg_of = step14_cfg_pkg::NEG_GROUND;
        end
    endfunction

    // Worked out from the reset word so the async branch loads constants only
    localparam logic [15:0] RESET_WORD = step14_cfg_pkg::STEP14_SETUP_RESET;
    localparam logic [3:0] POS_RESET = RESET_WORD[step14_cfg_pkg::POS_HI:step14_cfg_pkg::POS_LO];
    localparam logic [2:0] GAIN_RESET =
        gain_of(RESET_WORD[step14_cfg_pkg::GAIN_HI:step14_cfg_pkg::GAIN_LO]);
    localparam logic [7:0] EXT_RESET = POS_RESET[3] ? 8'h00 : src_onehot(POS_RESET[2:0]);
    localparam logic [7:0] INT_RESET = POS_RESET[3] ? src_onehot(POS_RESET[2:0]) : 8'h00;
    localparam step14_cfg_pkg::neg_route_type NEG_RESET =
        neg_of(POS_RESET, RESET_WORD[step14_cfg_pkg::NEG_POS]);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] setup_r;
    logic [15:0] rdata_r;
    logic [2:0] gain_r;
    logic [7:0] ext_pos_r;
    logic [7:0] int_src_r;
    step14_cfg_pkg::neg_route_type neg_route_r;
    wire logic hit;
    wire logic [15:0] setup_nxt;
    wire logic [15:0] rdata_nxt;
    wire logic [2:0] gain_nxt;
    wire logic [7:0] ext_pos_nxt;
    wire logic [7:0] int_src_nxt;
    step14_cfg_pkg::neg_route_type neg_route_nxt;

    assign hit = (addr_in == step14_cfg_pkg::STEP14_SETUP_ADDR); // R1
    // Reserved bits never store anything
    assign setup_nxt = (wr_in && hit) ? (wdata_in & step14_cfg_pkg::WRITABLE_MASK) : setup_r; // R8
    // Unmapped reads return zero
    assign rdata_nxt = (rd_in && hit) ? setup_r : 16'h0000;

    // ----------------------------------------
    // Routing decode
    // ----------------------------------------
    // Decoding the next word keeps the routed flip-flops in step with the register
    step14_route_decode u_decode (
        .gain_code_in(setup_nxt[step14_cfg_pkg::GAIN_HI:step14_cfg_pkg::GAIN_LO]),
        .neg_sel_in(setup_nxt[step14_cfg_pkg::NEG_POS]),
        .pos_sel_in(setup_nxt[step14_cfg_pkg::POS_HI:step14_cfg_pkg::POS_LO]),
        .gain_onehot_out(gain_nxt),
        .ext_pos_onehot_out(ext_pos_nxt),
        .int_src_onehot_out(int_src_nxt),
        .neg_route_out(neg_route_nxt)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup_r <= step14_cfg_pkg::STEP14_SETUP_RESET; // R1
            rdata_r <= 16'h0000;
        end else begin
            setup_r <= setup_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gain_r <= GAIN_RESET;
            ext_pos_r <= EXT_RESET;
            int_src_r <= INT_RESET;
            neg_route_r <= NEG_RESET;
        end else begin
            gain_r <= gain_nxt; // R3
            ext_pos_r <= ext_pos_nxt; // R5
            int_src_r <= int_src_nxt; // R6
            neg_route_r <= neg_route_nxt; // R4 R7
        end
    end

    assign rdata_out = rdata_r;
    assign step_enable_out = setup_r[step14_cfg_pkg::ENABLE_POS]; // R2
    assign gain_onehot_out = gain_r;
    assign ext_pos_onehot_out = ext_pos_r;
    assign int_src_onehot_out = int_src_r;
    assign neg_route_out = neg_route_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    reset_value_a: assert property (@(posedge clk_in) // R1
        $rose(rst_n_in) |-> setup_r == 16'h000E)
        else $error("reset value wrong");
    enable_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
        (wr_in && addr_in == 8'h9E) |=> step_enable_out == $past(wdata_in[15]))
        else $error("enable not stored");
    gain_four_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        setup_r[14] |-> gain_onehot_out == 3'h4)
        else $error("gain decode wrong");
    neg_ext_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
        (!setup_r[3] && setup_r[4]) |-> neg_route_out == step14_cfg_pkg::NEG_INPUT7)
        else $error("negative select wrong");
    pos_ext_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        !setup_r[3] |-> ext_pos_onehot_out[setup_r[2:0]] && int_src_onehot_out == 8'h00)
        else $error("external routing wrong");
    pos_int_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3] |-> int_src_onehot_out[setup_r[2:0]] && ext_pos_onehot_out == 8'h00)
        else $error("internal routing wrong");
    neg_auto_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
        setup_r[3] |-> neg_route_out == step14_cfg_pkg::NEG_AUTO)
        else $error("auto negative wrong");
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        rd_in |=> rdata_out[12:5] == 8'h00)
        else $error("reserved bits nonzero");
    read_back_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        (rd_in && addr_in == 8'h9E) |=> rdata_out == $past(setup_r))
        else $error("read data wrong");

    // ----------------------------------------
    // Gain and negative input checks
    // ----------------------------------------
    gain_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        setup_r[14:13] == 2'h0
        |-> gain_onehot_out == step14_cfg_pkg::GAIN_X1)
        else $error("gain one wrong");

    gain_two_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        setup_r[14:13] == 2'h1
        |-> gain_onehot_out == step14_cfg_pkg::GAIN_X2)
        else $error("gain two wrong");

    gain_ten_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        setup_r[14:13] == 2'h2
        |-> gain_onehot_out == step14_cfg_pkg::GAIN_X4)
        else $error("gain code two wrong");

    gain_eleven_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        setup_r[14:13] == 2'h3
        |-> gain_onehot_out == step14_cfg_pkg::GAIN_X4)
        else $error("gain code three wrong");

    gain_onehot_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        1'b1
        |-> $onehot(gain_onehot_out))
        else $error("gain not one-hot");

    neg_ground_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
        !setup_r[3] && !setup_r[4]
        |-> neg_route_out == step14_cfg_pkg::NEG_GROUND)
        else $error("ground reference wrong");

    neg_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
        setup_r[3] && setup_r[4]
        |-> neg_route_out == step14_cfg_pkg::NEG_AUTO)
        else $error("negative bit not ignored");

    neg_onehot_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
        1'b1
        |-> $onehot(neg_route_out))
        else $error("negative route not one-hot");

    // ----------------------------------------
    // Positive input checks
    // ----------------------------------------
    ext_in0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h0
        |-> ext_pos_onehot_out == 8'h01 && int_src_onehot_out == 8'h00)
        else $error("input 0 routing wrong");

    ext_in1_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h1
        |-> ext_pos_onehot_out == 8'h02 && int_src_onehot_out == 8'h00)
        else $error("input 1 routing wrong");

    ext_in2_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h2
        |-> ext_pos_onehot_out == 8'h04 && int_src_onehot_out == 8'h00)
        else $error("input 2 routing wrong");

    ext_in3_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h3
        |-> ext_pos_onehot_out == 8'h08 && int_src_onehot_out == 8'h00)
        else $error("input 3 routing wrong");

    ext_in4_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h4
        |-> ext_pos_onehot_out == 8'h10 && int_src_onehot_out == 8'h00)
        else $error("input 4 routing wrong");

    ext_in5_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h5
        |-> ext_pos_onehot_out == 8'h20 && int_src_onehot_out == 8'h00)
        else $error("input 5 routing wrong");

    ext_in6_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h6
        |-> ext_pos_onehot_out == 8'h40 && int_src_onehot_out == 8'h00)
        else $error("input 6 routing wrong");

    ext_in7_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        setup_r[3:0] == 4'h7
        |-> ext_pos_onehot_out == 8'h80 && int_src_onehot_out == 8'h00)
        else $error("input 7 routing wrong");

    temp_sensor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_TEMP_SENSOR
        |-> int_src_onehot_out == 8'h01 && ext_pos_onehot_out == 8'h00)
        else $error("temperature routing wrong");

    short_ground_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_SHORT_GND
        |-> int_src_onehot_out == 8'h02 && ext_pos_onehot_out == 8'h00)
        else $error("short routing wrong");

    test_dac_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_TEST_DAC
        |-> int_src_onehot_out == 8'h04 && ext_pos_onehot_out == 8'h00)
        else $error("test source routing wrong");

    analog_supply_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_ANALOG_SUPPLY
        |-> int_src_onehot_out == 8'h08 && ext_pos_onehot_out == 8'h00)
        else $error("analog supply routing wrong");

    io_supply_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_IO_SUPPLY
        |-> int_src_onehot_out == 8'h10 && ext_pos_onehot_out == 8'h00)
        else $error("io supply routing wrong");

    digital_supply_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_DIGITAL_SUPPLY
        |-> int_src_onehot_out == 8'h20 && ext_pos_onehot_out == 8'h00)
        else $error("digital supply routing wrong");

    analog_power_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_ANALOG_POWER
        |-> int_src_onehot_out == 8'h40 && ext_pos_onehot_out == 8'h00)
        else $error("analog power routing wrong");

    digital_power_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        setup_r[3:0] == step14_cfg_pkg::POS_DIGITAL_POWER
        |-> int_src_onehot_out == 8'h80 && ext_pos_onehot_out == 8'h00)
        else $error("digital power routing wrong");

    source_onehot_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        1'b1
        |-> $onehot({ext_pos_onehot_out, int_src_onehot_out}))
        else $error("positive source not one-hot");

    // ----------------------------------------
    // Register port checks
    // ----------------------------------------
    write_store_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        wr_in && addr_in == step14_cfg_pkg::STEP14_SETUP_ADDR
        |=> setup_r == ($past(wdata_in) & step14_cfg_pkg::WRITABLE_MASK))
        else $error("write not stored");

    write_miss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        !(wr_in && addr_in == step14_cfg_pkg::STEP14_SETUP_ADDR)
        |=> setup_r == $past(setup_r))
        else $error("register changed without write");

    read_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        !rd_in
        |=> rdata_out == 16'h0000)
        else $error("read data not cleared");

    read_miss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        rd_in && addr_in != step14_cfg_pkg::STEP14_SETUP_ADDR
        |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");

    reserved_held_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        1'b1
        |-> setup_r[12:5] == 8'h00)
        else $error("reserved bits stored");
endmodule

// ---- hdl/step14_route_decode.sv ----
`timescale 1ns/1ps
module step14_route_decode (
    // Fields
    input wire logic [1:0] gain_code_in,
    input wire logic neg_sel_in,
    input wire logic [3:0] pos_sel_in,
    // Decoded routing
    output logic [2:0] gain_onehot_out,
    output logic [7:0] ext_pos_onehot_out,
    output logic [7:0] int_src_onehot_out,
    output step14_cfg_pkg::neg_route_type neg_route_out
);
    wire logic internal_src;
    assign internal_src = pos_sel_in[3];
    // Codes 10 and 11 both give gain four
    assign gain_onehot_out = (gain_code_in == 2'h0) ? step14_cfg_pkg::GAIN_X1 : // R3
                             (gain_code_in == 2'h1) ? step14_cfg_pkg::GAIN_X2 :
                             step14_cfg_pkg::GAIN_X4;
    assign ext_pos_onehot_out = internal_src ? 8'h00 : (8'h01 << pos_sel_in[2:0]); // R5
    assign int_src_onehot_out = internal_src ? (8'h01 << pos_sel_in[2:0]) : 8'h00; // R6
    // Internal sources pick their own negative input; the select bit is ignored
    assign neg_route_out = internal_src ? step14_cfg_pkg::NEG_AUTO : // R7
                           (neg_sel_in ? step14_cfg_pkg::NEG_INPUT7 : // R4
                            step14_cfg_pkg::NEG_GROUND);
endmodule

// ---- test/aux_sequencer_step14_config_tb.sv ----
`timescale 1ns/1ps
module aux_sequencer_step14_config_tb;
    // ----------------------------------------
    // Ports and counters
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic step_enable_out;
    logic [2:0] gain_onehot_out;
    logic [7:0] ext_pos_onehot_out;
    logic [7:0] int_src_onehot_out;
    step14_cfg_pkg::neg_route_type neg_route_out;
    logic [15:0] d;
    int err_total = 0;
    int check_count = 0;
    step14_cfg_reg u_step14_cfg_reg (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .step_enable_out(step_enable_out), .gain_onehot_out(gain_onehot_out),
        .ext_pos_onehot_out(ext_pos_onehot_out), .int_src_onehot_out(int_src_onehot_out),
        .neg_route_out(neg_route_out));
    initial forever #2.5 clk_in = ~clk_in;
    // ----------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    // Expected sequencer view from the stored word
    task automatic chk_outs(input logic [15:0] v);
        chk({15'h0, step_enable_out}, {15'h0, v[15]});
        chk({13'h0, gain_onehot_out}, v[14] ? 16'h4 : (v[13] ? 16'h2 : 16'h1));
        chk({8'h0, ext_pos_onehot_out}, v[3] ? 16'h0 : 16'h1 << v[2:0]);
        chk({8'h0, int_src_onehot_out}, v[3] ? 16'h1 << v[2:0] : 16'h0);
        chk({13'h0, neg_route_out}, v[3] ? 16'h4 : (v[4] ? 16'h2 : 16'h1));
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1 chk(rdata_out, 16'h0000);
        chk_outs(16'h000E);
        rd(8'h9E, 16'h000E);
        @(posedge clk_in);
        #1 chk(rdata_out, 16'h0000);
        // Reserved bits are always written as ones to prove they are dropped
        for (int i = 0; i < 32; i++) begin
            d = {i[0], i[2:1], 8'hFF, i[4], i[3:0]};
            wr(8'h9E, d);
            chk_outs(d & 16'hE01F);
            rd(8'h9E, d & 16'hE01F);
        end
        wr(8'h9F, 16'hFFFF);
        chk_outs(d & 16'hE01F);
        rd(8'h9F, 16'h0000);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        #1 chk_outs(16'h000E);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h9E, 16'h000E);
        complete_run;
    end
    initial begin
        #5000;
        err_total++;
        complete_run;
    end
endmodule
